// ===== src/dmx_agu.sv
// Purpose: Prefetch address and pointer update for one data bus.
// Assumes: Byte addresses, word steps given as signed word counts.
// Notes: Purely combinational.
`timescale 1ns/1ns
module dmx_agu #(
	parameter int AW = 16
) (
	input wire logic [AW-1:0] ptr, // Base pointer value
	input wire logic [AW-1:0] offset, // Signed offset register
	input wire logic useOffset, // Register-offset mode
	input wire logic [2:0] step, // Signed word step -4..+3
	output logic [AW-1:0] addr, // Prefetch address
	output logic [AW-1:0] ptrNext // Pointer after the access
);
	logic [AW-1:0] stepBytes;

	generate
		if (AW < 4) begin : gBadWidth
			$error("dmx_agu: address width too small");
		end
	endgenerate

	// Sign-extended step doubled to bytes, never odd
	assign stepBytes = {{(AW-4){step[2]}}, step, 1'b0};
	// Old pointer or base plus offset addresses the read
	assign addr = useOffset ? ptr + offset : ptr;
	// Offset mode leaves the base untouched
	assign ptrNext = useOffset ? ptr : ptr + stepBytes;

endmodule : dmx_agu

// ===== src/dmx_mac_unit.sv
// Purpose: MAC-class and accumulator-only DSP execution unit.
// Assumes: Memory answers a read in the same cycle as the registered address.
// Notes: Operands read back the data of the previous issue by forwarding.
`timescale 1ns/1ns
module dmx_mac_unit (
	input wire logic clk, // Core clock
	input wire logic rstn, // Async reset, active low
	input wire logic opValid, // Operation issued this cycle
	input dmx_pkg::dmx_op_t opCode, // Operation
	input wire logic opAcc, // Target accumulator, 0 A, 1 B
	input wire logic [1:0] opMulA, // First multiplicand W4..W7
	input wire logic [1:0] opMulB, // Second multiplicand W4..W7
	input wire logic xEn, // X prefetch wanted
	input wire logic xPtrSel, // X pointer 0 W8, 1 W9
	input wire logic xOffset, // X register-offset mode
	input wire logic [2:0] xStep, // X signed word step
	input wire logic [1:0] xDest, // X destination W4..W7
	input wire logic yEn, // Y prefetch wanted
	input wire logic yPtrSel, // Y pointer 0 W10, 1 W11
	input wire logic yOffset, // Y register-offset mode
	input wire logic [2:0] yStep, // Y signed word step
	input wire logic [1:0] yDest, // Y destination W4..W7
	input dmx_pkg::dmx_wb_t wbMode, // Write-back mode
	input wire logic [5:0] opShift, // Literal shift, positive right
	input wire logic shiftFromReg, // Shift amount from register
	input wire logic [3:0] shiftReg, // Register number 4..13
	input wire logic [15:0] opWord, // Load or add word
	input wire logic fracMode, // Fractional multiply format
	input wire logic superSat, // Use all 40 bits
	input wire logic roundConv, // Convergent rounding
	input wire logic regWrEn, // Core write into W4..W13
	input wire logic [3:0] regWrIdx, // Register number 4..13
	input wire logic [15:0] regWrData, // Core write data
	input wire logic [15:0] xRdData, // X bus read data
	input wire logic [15:0] yRdData, // Y bus read data
	output logic xRdEn, // X bus read strobe
	output logic [15:0] xRdAddr, // X bus read address
	output logic yRdEn, // Y bus read strobe
	output logic [15:0] yRdAddr, // Y bus read address
	output logic wbWrEn, // Write-back memory strobe
	output logic [15:0] wbWrAddr, // Write-back address
	output logic [15:0] wbWrData, // Write-back data
	output logic stWrEn, // Accumulator store strobe
	output logic [15:0] stWrData, // Accumulator store data
	output logic opIllegal, // Issue refused
	output logic [39:0] accA, // Accumulator A
	output logic [39:0] accB, // Accumulator B
	output logic [159:0] wRegs // W4..W13, W4 lowest
);
	import dmx_pkg::*;

	dmx_state_t q;
	dmx_state_t d;
	logic [15:0] xBase;
	logic [15:0] yBase;
	logic [15:0] xAddr;
	logic [15:0] xPtrNew;
	logic [15:0] yAddr;
	logic [15:0] yPtrNew;
	logic [15:0] wbWord;
	logic [15:0] stWord;
	logic macClass;
	logic wbOk;
	logic isEd;
	logic bad;
	logic [3:0] regIdx;
	logic [3:0] shIdx;
	logic [5:0] amt;
	logic [5:0] negAmt;
	logic signed [15:0] mA;
	logic signed [15:0] mB;
	logic signed [31:0] prod;
	logic signed [39:0] p40;
	logic signed [39:0] tgt;
	logic signed [39:0] oth;
	logic signed [39:0] res;
	logic accWr;

	// Base pointers for the two buses
	assign xBase = xPtrSel ? q.w[IDX_W9] : q.w[IDX_W8];
	assign yBase = yPtrSel ? q.w[IDX_W11] : q.w[IDX_W10];

	dmx_agu #(
		.AW(WORD_W)
	) uAguX (
		.ptr(xBase),
		.offset(q.w[IDX_W12]),
		.useOffset(xOffset),
		.step(xStep),
		.addr(xAddr),
		.ptrNext(xPtrNew)
	);

	dmx_agu #(
		.AW(WORD_W)
	) uAguY (
		.ptr(yBase),
		.offset(q.w[IDX_W12]),
		.useOffset(yOffset),
		.step(yStep),
		.addr(yAddr),
		.ptrNext(yPtrNew)
	);

	// The unused accumulator feeds write back
	dmx_round uRoundWb (
		.acc(q.acc[~opAcc]),
		.convergent(roundConv),
		.word(wbWord)
	);

	// The target accumulator feeds the rounded store
	dmx_round uRoundSt (
		.acc(q.acc[opAcc]),
		.convergent(roundConv),
		.word(stWord)
	);

	// Issue checks
	assign macClass = opCode inside {OP_CLEAR, OP_MOVE_AND_STORE_ACC, OP_MAC, OP_MSC,
		OP_MPY, OP_MPYN, OP_ED, OP_EUCLID_DISTANCE_ACCUM};
	assign isEd = opCode inside {OP_ED, OP_EUCLID_DISTANCE_ACCUM};
	assign wbOk = (opCode inside {OP_CLEAR, OP_MOVE_AND_STORE_ACC, OP_MSC}) ||
		(opCode == OP_MAC && opMulA != opMulB);
	assign bad = macClass && (
		(xEn && xOffset && !xPtrSel) || (yEn && yOffset && !yPtrSel) ||
		(wbMode != WB_NONE && !wbOk) ||
		(isEd && (!(xEn && yEn) || opMulA != opMulB)));
	assign regIdx = regWrIdx - W_LO_IDX;
	assign shIdx = shiftReg - W_LO_IDX;
	assign negAmt = 6'h00 - amt;

	// Next state of the whole unit
	always_comb begin
		d = q;
		d.xRdEn = 1'b0;
		d.yRdEn = 1'b0;
		d.wbWrEn = 1'b0;
		d.stWrEn = 1'b0;
		d.illegal = 1'b0;
		d.xPend = 1'b0;
		d.yPend = 1'b0;
		d.edPend = 1'b0;
		amt = opShift;
		mA = '0;
		mB = '0;
		prod = '0;
		p40 = '0;
		tgt = q.acc[opAcc];
		oth = q.acc[~opAcc];
		res = tgt;
		accWr = 1'b0;
		// Data of last issue lands in W4..W7, difference for Euclid
		if (q.edPend) begin
			d.w[{2'b00, q.xDst}] = xRdData - yRdData;
		end else begin
			if (q.xPend) begin
				d.w[{2'b00, q.xDst}] = xRdData;
			end
			if (q.yPend) begin
				d.w[{2'b00, q.yDst}] = yRdData;
			end
		end
		// Operands see the forwarded values
		mA = d.w[{2'b00, opMulA}];
		mB = d.w[{2'b00, opMulB}];
		prod = mA * mB;
		p40 = {{8{prod[31]}}, prod};
		if (fracMode) begin
			p40 = p40 <<< 1;
		end
		if (shiftFromReg && shiftReg >= W_LO_IDX && shiftReg <= W_HI_IDX) begin
			amt = d.w[shIdx][5:0];
		end
		if (opValid && bad) begin
			d.illegal = 1'b1;
		end else if (opValid) begin
			// Two reads and pointer moves in the issue cycle
			if (macClass && xEn) begin
				d.xRdEn = 1'b1;
				d.xRdAddr = xAddr;
				d.w[xPtrSel ? IDX_W9 : IDX_W8] = xPtrNew;
				d.xPend = !isEd;
				d.edPend = isEd;
				d.xDst = xDest;
			end
			if (macClass && yEn) begin
				d.yRdEn = 1'b1;
				d.yRdAddr = yAddr;
				d.w[yPtrSel ? IDX_W11 : IDX_W10] = yPtrNew;
				d.yPend = !isEd;
				d.yDst = yDest;
			end
			// Rounded other accumulator through W13
			if (macClass && wbMode == WB_DIRECT) begin
				d.w[IDX_W13] = wbWord;
			end else if (macClass && wbMode == WB_POSTINC) begin
				d.wbWrEn = 1'b1;
				d.wbWrAddr = q.w[IDX_W13];
				d.wbWrData = wbWord;
				d.w[IDX_W13] = q.w[IDX_W13] + WB_STEP;
			end
			// Arithmetic on the target accumulator
			accWr = 1'b1;
			unique case (opCode)
				OP_CLEAR: res = '0;
				OP_MAC: res = tgt + p40;
				OP_MSC: res = tgt - p40;
				OP_MPY: res = p40;
				OP_MPYN: res = -p40;
				OP_ED: res = p40;
				OP_EUCLID_DISTANCE_ACCUM: res = tgt + p40;
				OP_ADDAB: res = tgt + oth;
				OP_SUBAB: res = tgt - oth;
				OP_ADDW: res = tgt + {{8{opWord[15]}}, opWord, 16'h0000};
				OP_NEG: res = -tgt;
				OP_SHIFT: begin
					if (amt[5]) begin
						res = tgt <<< negAmt;
					end else begin
						res = tgt >>> amt;
					end
				end
				OP_LOAD: res = {{8{opWord[15]}}, opWord, 16'h0000};
				OP_STORE: begin
					accWr = 1'b0;
					d.stWrEn = 1'b1;
					d.stWrData = q.acc[opAcc][31:16];
				end
				OP_STORER: begin
					accWr = 1'b0;
					d.stWrEn = 1'b1;
					d.stWrData = stWord;
				end
				OP_MOVE_AND_STORE_ACC: accWr = 1'b0;
				OP_NOP: accWr = 1'b0;
				default: accWr = 1'b0;
			endcase
			// Guard byte follows bit 31 unless 40 bits are in use
			if (!superSat) begin
				res = {{8{res[31]}}, res[31:0]};
			end
			if (accWr) begin
				d.acc[opAcc] = res;
			end
		end
		// Core register writes take last say
		if (regWrEn && regWrIdx >= W_LO_IDX && regWrIdx <= W_HI_IDX) begin
			d.w[regIdx] = regWrData;
		end
	end

	// State register
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// Outputs straight from state
	assign xRdEn = q.xRdEn;
	assign xRdAddr = q.xRdAddr;
	assign yRdEn = q.yRdEn;
	assign yRdAddr = q.yRdAddr;
	assign wbWrEn = q.wbWrEn;
	assign wbWrAddr = q.wbWrAddr;
	assign wbWrData = q.wbWrData;
	assign stWrEn = q.stWrEn;
	assign stWrData = q.stWrData;
	assign opIllegal = q.illegal;
	assign accA = q.acc[0];
	assign accB = q.acc[1];
	assign wRegs = q.w;

endmodule : dmx_mac_unit

// ===== src/dmx_pkg.sv
// Purpose: Shared constants and types of the DSP MAC execution unit.
// Assumes: 16-bit working registers, two 40-bit accumulators, one clock.
// Notes: Working registers 4..13 live inside the unit at index Wn-4.
// Notes on behaviour
// - Each MAC-class op issues in one cycle: two reads, two updates, one op.
// - X prefetch address from W8 or W9, Y prefetch from W10 or W11.
// - Prefetched operands land only in W4..W7, as the op selects.
// - Offset mode address is base pointer plus signed W12.
// - Offset mode allowed only with W9 for X and W11 for Y.
// - Pointer moves after prefetch by -8..+6 bytes in even steps.
// - Offset mode leaves base pointer and W12 unchanged.
// - Multiply ops take W4..W7 in any pair; store, add, negate or subtract.
// - Same register twice gives a square or square-and-accumulate.
// - Euclid ops store X minus Y difference, not the words; one operand.
// - Two Euclid variants: square only, or square and accumulate.
// - Clear zeroes an accumulator, may prefetch and write back the other.
// - Move-and-store prefetches and stores, no accumulator changes.
// - Write back stores rounded unused accumulator through W13, same cycle.
// - Write back into W13 itself, or memory at W13 then W13 += 2.
// - Write back only for clear, move-store, subtract, two-register MAC.
// - Written-back accumulator is implied: the one the op leaves alone.
// - Accumulator-only ops: no prefetch, no write back; 40-bit ops.
// - Accumulators add or subtract each other; 16-bit signed add too.
// - Arithmetic accumulator shift by literal or working register.
// - Plain store and rounded store of an accumulator.
// - Load puts word in high part, zero low word, sign-extend guard byte.
// - Fractional format shifts DSP products left one bit.
// - Super-saturation uses 40 bits, else 32 with sign-extended top byte.
package dmx_pkg;

	localparam int WORD_W = 16;
	localparam int ACC_W = 40;
	localparam int W_LO = 4;
	localparam logic [3:0] W_LO_IDX = 4'h4;
	localparam logic [3:0] W_HI_IDX = 4'hd;
	// Local register file indices, Wn minus four
	localparam logic [3:0] IDX_W8 = 4'h4;
	localparam logic [3:0] IDX_W9 = 4'h5;
	localparam logic [3:0] IDX_W10 = 4'h6;
	localparam logic [3:0] IDX_W11 = 4'h7;
	localparam logic [3:0] IDX_W12 = 4'h8;
	localparam logic [3:0] IDX_W13 = 4'h9;
	localparam logic [15:0] WB_STEP = 16'h0002;
	localparam logic [15:0] ROUND_HALF = 16'h8000;
	localparam logic [39:0] ACC_RESET = 40'h00_0000_0000;

	typedef enum logic [4:0] {
		OP_CLEAR = 5'b00000,
		OP_MOVE_AND_STORE_ACC = 5'b00001,
		OP_MAC = 5'b00010,
		OP_MSC = 5'b00011,
		OP_MPY = 5'b00100,
		OP_MPYN = 5'b00101,
		OP_ED = 5'b00110,
		OP_EUCLID_DISTANCE_ACCUM = 5'b00111,
		OP_ADDAB = 5'b01000,
		OP_SUBAB = 5'b01001,
		OP_ADDW = 5'b01010,
		OP_NEG = 5'b01011,
		OP_SHIFT = 5'b01100,
		OP_LOAD = 5'b01101,
		OP_STORE = 5'b01110,
		OP_STORER = 5'b01111,
		OP_NOP = 5'b10000
	} dmx_op_t;

	typedef enum logic [1:0] {
		WB_NONE = 2'b00,
		WB_DIRECT = 2'b01,
		WB_POSTINC = 2'b10
	} dmx_wb_t;

	typedef struct packed {
		logic [1:0][39:0] acc;
		logic [9:0][15:0] w;
		logic xPend;
		logic yPend;
		logic edPend;
		logic [1:0] xDst;
		logic [1:0] yDst;
		logic xRdEn;
		logic [15:0] xRdAddr;
		logic yRdEn;
		logic [15:0] yRdAddr;
		logic wbWrEn;
		logic [15:0] wbWrAddr;
		logic [15:0] wbWrData;
		logic stWrEn;
		logic [15:0] stWrData;
		logic illegal;
	} dmx_state_t;

endpackage : dmx_pkg

// ===== src/dmx_round.sv
// Purpose: Round an accumulator to its 16-bit high word.
// Assumes: Value is 1.31 aligned in bits 31..0.
// Notes: Half-up by default, convergent when selected.
`timescale 1ns/1ns
module dmx_round
	import dmx_pkg::*;
(
	input wire logic [39:0] acc, // Accumulator value
	input wire logic convergent, // Round half to even
	output logic [15:0] word // Rounded high word
);
	logic tie;
	logic up;

	// Tie when the low word is exactly one half
	assign tie = acc[15:0] == ROUND_HALF;
	assign up = convergent ? (acc[15] && (!tie || acc[16])) : acc[15];
	assign word = acc[31:16] + {15'h0000, up};

endmodule : dmx_round

// ===== verif/dmx_mac_checker.sv
// Purpose: Port assertions of the DSP MAC execution unit.
// Assumes: One clock; any MAC-class issue may be refused.
// Notes: Bound from the bench top file.
`timescale 1ns/1ns
module dmx_mac_checker
	import dmx_pkg::*;
(
	input wire logic clk, // Clock
	input wire logic rstn, // Reset
	input wire logic opValid, // Issue
	input dmx_pkg::dmx_op_t opCode, // Op
	input wire logic opAcc, // Target
	input wire logic xEn, // X fetch
	input wire logic xPtrSel, // X pointer
	input wire logic xOffset, // X offset mode
	input wire logic [2:0] xStep, // X step
	input wire logic yEn, // Y fetch
	input wire logic yOffset, // Y offset mode
	input dmx_pkg::dmx_wb_t wbMode, // Write back
	input wire logic [15:0] opWord, // Word
	input wire logic regWrEn, // Core write
	input wire logic xRdEn, // X strobe
	input wire logic [15:0] xRdAddr, // X addr
	input wire logic yRdEn, // Y strobe
	input wire logic [15:0] yRdAddr, // Y addr
	input wire logic wbWrEn, // WB strobe
	input wire logic [15:0] wbWrAddr, // WB addr
	input wire logic opIllegal, // Refused
	input wire logic [39:0] accA, // Acc A
	input wire logic [39:0] accB, // Acc B
	input wire logic [159:0] wRegs // W4..W13
);
	logic [15:0] w8, w13, yOff, xInc;
	logic [39:0] ldVal;
	// Pointer views and derived values
	assign w8 = wRegs[79:64];
	assign w13 = wRegs[159:144];
	assign yOff = wRegs[127:112] + wRegs[143:128];
	assign xInc = {{12{xStep[2]}}, xStep, 1'b0};
	assign ldVal = {{8{opWord[15]}}, opWord, 16'h0000};
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	sequence sMac;
		opValid && opCode <= OP_EUCLID_DISTANCE_ACCUM;
	endsequence
	sequence sXFetch;
		sMac ##0 (xEn && !xOffset && !xPtrSel);
	endsequence
	sequence sQuiet;
		!xRdEn && !yRdEn && !wbWrEn;
	endsequence
	AST_X_ADDR: assert property (
		sXFetch |=> opIllegal || (xRdEn && xRdAddr == $past(w8)))
		else $error("X prefetch address wrong");
	AST_X_STEP: assert property (
		sXFetch ##0 !regWrEn |=> opIllegal || w8 == $past(w8) + $past(xInc))
		else $error("X pointer update wrong");
	AST_Y_OFFSET: assert property (
		sMac ##0 (yEn && yOffset && !regWrEn) |=> opIllegal
			|| (yRdAddr == $past(yOff) && $stable(wRegs[143:112])))
		else $error("Y offset prefetch wrong");
	AST_OFFSET_W8: assert property (
		sMac ##0 (xEn && xOffset && !xPtrSel) |=> opIllegal)
		else $error("Offset on W8 not refused");
	AST_WB_REFUSED: assert property (
		opValid && opCode inside {OP_ED, OP_EUCLID_DISTANCE_ACCUM, OP_MPY, OP_MPYN}
			&& wbMode != WB_NONE |=> opIllegal)
		else $error("Write back not refused");
	AST_WB_POSTINC: assert property (
		opValid && opCode == OP_MOVE_AND_STORE_ACC && wbMode == WB_POSTINC && !regWrEn
			|=> opIllegal || (wbWrEn && wbWrAddr == $past(w13)
			&& w13 == $past(w13) + 16'h0002))
		else $error("Write back post-increment wrong");
	AST_MOVE_KEEPS: assert property (
		opValid && opCode == OP_MOVE_AND_STORE_ACC |=> $stable(accA) && $stable(accB))
		else $error("Move-and-store changed an accumulator");
	AST_ACC_ONLY: assert property (
		opValid && opCode inside {[OP_ADDAB:OP_STORER]} |=> sQuiet)
		else $error("Accumulator op used a bus");
	AST_LOAD_A: assert property (
		opValid && opCode == OP_LOAD && !opAcc |=> accA == $past(ldVal))
		else $error("Accumulator load wrong");
endmodule : dmx_mac_checker

// ===== verif/dmx_mem_model.sv
// Purpose: X and Y data memory seen by the MAC unit.
// Assumes: Read data is due in the cycle of each read strobe.
// Notes: Off the strobe the data lines carry a moving pattern.
`timescale 1ns/1ns
module dmx_mem_model (
	input wire logic clk, // Core clock
	input wire logic xRdEn, // X read strobe
	input wire logic [15:0] xRdAddr, // X address
	input wire logic yRdEn, // Y read strobe
	input wire logic [15:0] yRdAddr, // Y address
	output logic [15:0] xRdData, // X read data
	output logic [15:0] yRdData // Y read data
);
	logic [15:0] junk = 16'ha5a5;
	// Pattern steps every cycle so stale data never matches
	always_ff @(posedge clk) begin
		junk <= junk + 16'h1357;
	end
	// Contents are a fixed function of the address
	assign xRdData = xRdEn ? xRdAddr ^ 16'h3c5a : junk;
	assign yRdData = yRdEn ? yRdAddr ^ 16'h9e17 : ~junk;
endmodule : dmx_mem_model

// ===== verif/tb.sv
// Purpose: Self-checking bench for the DSP MAC execution unit.
// Assumes: Memory model answers in the cycle of each read strobe.
// Notes: Random multiply runs use a fixed seed.
`timescale 1ns/1ns
module tb;
	import dmx_pkg::*;
	logic clk, rstn, opValid, opAcc, xEn, xPtrSel, xOffset, yEn, yPtrSel;
	logic yOffset, shiftFromReg, fracMode, superSat, roundConv, regWrEn;
	logic xRdEn, yRdEn, wbWrEn, stWrEn, opIllegal;
	logic [1:0] opMulA, opMulB, xDest, yDest;
	logic [2:0] xStep, yStep;
	logic [3:0] shiftReg, regWrIdx;
	logic [5:0] opShift;
	logic [15:0] opWord, regWrData, xRdData, yRdData, xRdAddr, yRdAddr;
	logic [15:0] wbWrAddr, wbWrData, stWrData, ra, rb;
	logic [39:0] accA, accB, ea, eb, p;
	logic [159:0] wRegs;
	dmx_op_t opCode;
	dmx_wb_t wbMode;
	dmx_op_t ops[5] = '{OP_ADDAB, OP_SUBAB, OP_NEG, OP_SHIFT, OP_ADDW};
	integer seed = 32'h4bac;
	int failures = 0;
	int check_count = 0;
	int k;

	dmx_mac_unit uut (.*);
	dmx_mem_model mem (.*);

	// Core clock, 100 MHz
	always #5 clk = ~clk;

	function automatic logic [15:0] w(int n);
		return wRegs[16*(n-4) +: 16];
	endfunction : w

	function automatic logic [39:0] prod(logic [15:0] a, b, logic f);
		logic [39:0] r;
		r = $signed({{24{a[15]}}, a}) * $signed({{24{b[15]}}, b});
		return f ? r << 1 : r;
	endfunction : prod

	// Half-up, or half-to-even on an exact tie when c is set
	function automatic logic [15:0] rnd(logic [39:0] a, logic c);
		logic up;
		up = a[15] && (!c || a[14:0] != 15'h0000 || a[16]);
		return a[31:16] + {15'h0000, up};
	endfunction : rnd

	function automatic logic [39:0] expa(dmx_op_t o);
		logic [39:0] a;
		a = 40'hff_c000_0000;
		case (o)
			OP_ADDAB: return a + eb;
			OP_SUBAB: return a - eb;
			OP_NEG: return -a;
			OP_SHIFT: return $signed(a) >>> 2;
			default: return a + a;
		endcase
	endfunction : expa

	task automatic complete_run;
		if (failures == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : complete_run

	task automatic chk(logic [79:0] g, e);
		check_count++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %0t got %h expected %h", $time, g, e);
		end
	endtask : chk

	task automatic wr(logic [3:0] i, logic [15:0] d);
		@(posedge clk);
		regWrEn <= 1'b1;
		regWrIdx <= i;
		regWrData <= d;
		@(posedge clk);
		regWrEn <= 1'b0;
	endtask : wr

	// Issue one op; returns just after the edge that takes it
	task automatic iss(dmx_op_t op, logic a, logic [1:0] ma, mb);
		@(posedge clk);
		opValid <= 1'b1;
		opCode <= op;
		opAcc <= a;
		opMulA <= ma;
		opMulB <= mb;
		@(posedge clk);
		{opValid, xEn, yEn, xOffset, yOffset} <= '0;
		wbMode <= WB_NONE;
		#1;
	endtask : iss

	task automatic ld(logic a, logic [15:0] d);
		@(posedge clk);
		opWord <= d;
		iss(OP_LOAD, a, 2'h0, 2'h0);
	endtask : ld

	// Watchdog, far beyond the expected run
	initial begin
		#200000;
		failures++;
		complete_run;
	end

	// Directed corners, random multiplies, then a 32-bit guard byte check
	initial begin
		{opValid, opAcc, opMulA, opMulB, xEn, xPtrSel, xOffset, xStep, xDest,
			yEn, yPtrSel, yOffset, yStep, yDest, shiftFromReg, shiftReg,
			opWord, roundConv, regWrEn, regWrIdx, regWrData, clk, rstn} = '0;
		{superSat, fracMode} = 2'h3;
		opShift = 6'h02;
		opCode = OP_NOP;
		wbMode = WB_NONE;
		eb = 40'hff_8001_0000;
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		wr(4'h4, 16'h4000);
		wr(4'h5, 16'h2000);
		wr(4'h8, 16'h0100);
		wr(4'ha, 16'h0200);
		wr(4'hb, 16'h0400);
		wr(4'hc, 16'hfffe);
		wr(4'hd, 16'h0300);
		ld(1'b1, 16'h8001);
		chk(accB, eb);
		iss(OP_MPY, 1'b0, 2'h0, 2'h1);
		chk(accA, 40'h00_1000_0000);
		@(posedge clk);
		{xEn, yEn, xStep, yStep} <= 8'hcf;
		{xDest, yDest} <= 4'hb;
		wbMode <= WB_POSTINC;
		iss(OP_MAC, 1'b0, 2'h0, 2'h1);
		chk(accA, 40'h00_2000_0000);
		chk({xRdAddr, yRdAddr}, 32'h0100_0200);
		chk({w(8), w(10)}, 32'h0102_01fe);
		chk({wbWrEn, wbWrAddr, wbWrData}, 33'h1_0300_8001);
		chk(w(13), 16'h0302);
		@(posedge clk);
		#1;
		chk({w(6), w(7)}, {16'h0100 ^ 16'h3c5a, 16'h0200 ^ 16'h9e17});
		@(posedge clk);
		{xEn, yEn, yPtrSel, yOffset} <= 4'hf;
		{xStep, xDest, yDest} <= '0;
		iss(OP_ED, 1'b0, 2'h2, 2'h2);
		@(posedge clk);
		#1;
		chk(w(4), 16'((16'h0102 ^ 16'h3c5a) - (16'h03fe ^ 16'h9e17)));
		chk({w(11), w(12)}, 32'h0400_fffe);
		ea = accA;
		@(posedge clk);
		wbMode <= WB_DIRECT;
		iss(OP_MPY, 1'b0, 2'h0, 2'h1);
		chk({opIllegal, accA}, {1'b1, ea});
		@(posedge clk);
		{xEn, xOffset} <= 2'h3;
		iss(OP_MOVE_AND_STORE_ACC, 1'b0, 2'h0, 2'h0);
		chk(opIllegal, 1'b1);
		@(posedge clk);
		wbMode <= WB_DIRECT;
		iss(OP_CLEAR, 1'b0, 2'h0, 2'h0);
		chk({accA, w(13)}, {40'h0, 16'h8001});
		@(posedge clk);
		wbMode <= WB_POSTINC;
		iss(OP_MOVE_AND_STORE_ACC, 1'b1, 2'h0, 2'h0);
		chk({accB, wbWrAddr, w(13)}, {eb, 32'h8001_8003});
		foreach (ops[i]) begin
			ld(1'b0, 16'hc000);
			iss(ops[i], 1'b0, 2'h0, 2'h0);
			chk(accA, expa(ops[i]));
		end
		ld(1'b1, 16'h0000);
		eb = '0;
		repeat (24) begin
			ra = 16'($random(seed));
			rb = 16'($random(seed));
			k = $unsigned($random(seed)) % 4;
			wr(4'h4, ra);
			wr(4'h5, rb);
			@(posedge clk);
			fracMode <= ra[0];
			roundConv <= rb[1];
			iss(dmx_op_t'(5'd2 + 5'(k)), 1'b1, 2'h0, {1'b0, rb[0]});
			p = prod(ra, rb[0] ? rb : ra, ra[0]);
			eb = k == 0 ? eb + p : k == 1 ? eb - p : k == 2 ? p : -p;
			chk(accB, eb);
			iss(OP_STORE, 1'b1, 2'h0, 2'h0);
			chk({stWrEn, stWrData}, {1'b1, eb[31:16]});
			iss(OP_STORER, 1'b1, 2'h0, 2'h0);
			chk({stWrEn, stWrData}, {1'b1, rnd(eb, rb[1])});
		end
		@(posedge clk);
		superSat <= 1'b0;
		ld(1'b0, 16'h7fff);
		ld(1'b1, 16'h7fff);
		iss(OP_ADDAB, 1'b0, 2'h0, 2'h0);
		chk(accA, 40'hff_fffe_0000);
		complete_run;
	end
endmodule : tb

bind dmx_mac_unit dmx_mac_checker chk (.*);
